// file: bench/pcc_board.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_board (
  input wire logic rst_n_i,
  input wire logic [2:0] mode_i,
  input wire logic [8:0] pulldown_i,
  output logic crystal_o,
  output logic [8:0] strap_pulldown_o,
  output logic pll_test_select_o,
  output logic selftest_select_o,
  output logic scan_select_o
);
  // Free-running crystal near 18.43 MHz
  localparam realtime HALF_NS = 27.125;
  initial crystal_o = 1'b0;
  always #(HALF_NS) crystal_o = ~crystal_o;

  // Board strapping of address lines and mode pins
  assign strap_pulldown_o = pulldown_i;
  assign pll_test_select_o = mode_i[2];
  assign selftest_select_o = mode_i[1];
  assign scan_select_o = (mode_i == 3'h4 || mode_i == 3'h6) ? ~rst_n_i : mode_i[0];
endmodule : pcc_board
`default_nettype wire

// file: bench/pcc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_top_sva
  import pcc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic [PCC_STRAP_W-1:0] STRAP_PULLDOWN_I,
  input wire logic PLL_TEST_SELECT_I,
  input wire logic SELFTEST_SELECT_I,
  input wire logic SCAN_SELECT_I,
  input wire logic CRYSTAL_IN_I,
  input wire logic BUS_CLK_O,
  input wire logic PLL_MODE_O,
  input wire logic DEBUG_MODE_O,
  input wire logic MODE_VALID_O,
  input wire logic [1:0] CHARGE_PUMP_SEL_O,
  input wire logic [1:0] OUTPUT_DIVIDER_SEL_O,
  input wire logic [4:0] FEEDBACK_MULTIPLIER_O
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [2:0] up;
  logic [2:0] code;
  logic [8:0] fields;
  logic acc;
  logic spd_wr;
  logic [5:0] m1;

  // Decoded views of pins and bus
  assign code = {PLL_TEST_SELECT_I, SELFTEST_SELECT_I, SCAN_SELECT_I};
  assign fields = {CHARGE_PUMP_SEL_O, OUTPUT_DIVIDER_SEL_O, FEEDBACK_MULTIPLIER_O};
  assign acc = PSEL_I && PENABLE_I;
  assign spd_wr = acc && PWRITE_I && PSTRB_I[3] && PADDR_I == PCC_SPEED_ADDR;
  assign m1 = {2'h0, PWDATA_I[27:24]} + 6'h05;

  // Cycles since reset release, saturating
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end

  // Charge-pump band of a multiplier-plus-one
  function automatic logic [1:0] band(input logic [5:0] m);
    return (m < 6'h04) ? 2'h0 : (m < 6'h08) ? 2'h1 : (m < 6'h10) ? 2'h2 : 2'h3;
  endfunction : band

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence code_settled;
    (up == 3'h7 && $stable(code))[*4];
  endsequence
  sequence xtal_settled;
    (up == 3'h7 && !PLL_MODE_O && $stable(PLL_MODE_O) && $stable(CRYSTAL_IN_I))[*5];
  endsequence

  AST_MODE_DECODE: assert property (code_settled |->
    {PLL_MODE_O, DEBUG_MODE_O, MODE_VALID_O} == {code[2] && !code[0], code[2] && code[1],
    code inside {3'h3, 3'h4, 3'h6, 3'h7}}) else $error("Mode outputs disagree with select code");
  AST_EXT_PASS: assert property (xtal_settled |-> BUS_CLK_O == CRYSTAL_IN_I)
    else $error("Bus clock does not follow oscillator");
  AST_STRAP_LOAD: assert property (up == 3'h4 && $stable(STRAP_PULLDOWN_I) |->
    fields == (~STRAP_PULLDOWN_I ^ 9'h0f4)) else $error("Settings not loaded from straps");
  AST_HOLD: assert property (up == 3'h7 && !spd_wr |=> $stable(fields))
    else $error("Settings changed without speed write");
  AST_SPEED_MUL: assert property (spd_wr |=> FEEDBACK_MULTIPLIER_O == $past(m1[4:0]) - 5'h01)
    else $error("Multiplier not set from speed code");
  AST_SPEED_CP: assert property (spd_wr |=> CHARGE_PUMP_SEL_O == band($past(m1)))
    else $error("Charge pump not set from speed code");
  AST_SPEED_DIV: assert property (spd_wr |=> $stable(OUTPUT_DIVIDER_SEL_O))
    else $error("Divider changed by speed write");
  AST_NO_WRITE: assert property (acc && PWRITE_I && PADDR_I == PCC_SETTINGS_ADDR |->
    PSLVERR_O ##1 $stable(fields)) else $error("Settings write not refused");
  AST_READBACK: assert property (acc && !PWRITE_I && PADDR_I == PCC_SETTINGS_ADDR |->
    PRDATA_O == {23'h0, fields}) else $error("Settings readback wrong");
endmodule : pcc_top_sva

bind pcc_top pcc_top_sva u_sva (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
  .STRAP_PULLDOWN_I(STRAP_PULLDOWN_I), .PLL_TEST_SELECT_I(PLL_TEST_SELECT_I),
  .SELFTEST_SELECT_I(SELFTEST_SELECT_I), .SCAN_SELECT_I(SCAN_SELECT_I), .CRYSTAL_IN_I(CRYSTAL_IN_I),
  .BUS_CLK_O(BUS_CLK_O), .PLL_MODE_O(PLL_MODE_O), .DEBUG_MODE_O(DEBUG_MODE_O), .MODE_VALID_O(MODE_VALID_O),
  .CHARGE_PUMP_SEL_O(CHARGE_PUMP_SEL_O), .OUTPUT_DIVIDER_SEL_O(OUTPUT_DIVIDER_SEL_O),
  .FEEDBACK_MULTIPLIER_O(FEEDBACK_MULTIPLIER_O)
);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcc_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] pd;
  logic [2:0] md;
  logic [8:0] strap;
  logic pts;
  logic sts;
  logic scs;
  logic xtal;
  logic bus_clk;
  logic ref_clk;
  logic pll_m;
  logic dbg_m;
  logic val_m;
  logic [1:0] cps;
  logic [1:0] dvs;
  logic [4:0] mul;
  int fails;
  int comparisons;

  pcc_top dut (
    .CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STRAP_PULLDOWN_I(strap), .PLL_TEST_SELECT_I(pts), .SELFTEST_SELECT_I(sts),
    .SCAN_SELECT_I(scs), .CRYSTAL_IN_I(xtal), .BUS_CLK_O(bus_clk), .SLOW_REF_CLOCK_O(ref_clk),
    .PLL_MODE_O(pll_m), .DEBUG_MODE_O(dbg_m), .MODE_VALID_O(val_m), .CHARGE_PUMP_SEL_O(cps),
    .OUTPUT_DIVIDER_SEL_O(dvs), .FEEDBACK_MULTIPLIER_O(mul)
  );
  pcc_board board (
    .rst_n_i(rstn), .mode_i(md), .pulldown_i(pd), .crystal_o(xtal), .strap_pulldown_o(strap),
    .pll_test_select_o(pts), .selftest_select_o(sts), .scan_select_o(scs)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // One APB transfer, then an idle edge; read data checked on reads
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [31:0] exp,
                      input logic eerr);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    // A slave that never answers counts against the run
    if (n >= 100) begin
      fails++;
      $display("MISMATCH t=%0t no ready on address %h", $time, a);
    end
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, eerr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic boot(input logic [8:0] p, input logic [2:0] m);
    rstn <= 1'b0;
    pd <= p;
    md <= m;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : boot

  // Rising edges of bus and reference clocks over 20 crystal periods
  task automatic measure(input int lo, input int hi);
    int nb;
    int nr;
    int nx;
    logic pb;
    logic pr;
    logic px;
    repeat (3) @(posedge xtal);
    @(negedge clk);
    nb = 0;
    nr = 0;
    nx = 0;
    pb = bus_clk;
    pr = ref_clk;
    px = xtal;
    while (nx < 20) begin
      @(negedge clk);
      nb += int'(bus_clk && !pb);
      nr += int'(ref_clk && !pr);
      nx += int'(xtal && !px);
      pb = bus_clk;
      pr = ref_clk;
      px = xtal;
    end
    chk(32'(nb >= lo && nb <= hi), 32'h1);
    chk(32'(nr >= 3 && nr <= 5), 32'h1);
    @(posedge clk);
  endtask : measure

  task automatic mode_chk(input logic [2:0] m);
    logic [2:0] e;
    e = {m inside {3'h3, 3'h4, 3'h6, 3'h7}, m == 3'h6 || m == 3'h7, m == 3'h4 || m == 3'h6};
    md <= m;
    repeat (6) @(posedge clk);
    chk({29'h0, val_m, dbg_m, pll_m}, {29'h0, e});
    xfer(1'b0, PCC_MODE_ADDR, 32'h0, {25'h0, m, 1'b0, e}, 1'b0);
  endtask : mode_chk

  function automatic logic [1:0] band(input int m);
    return (m < 4) ? 2'h0 : (m < 8) ? 2'h1 : (m < 16) ? 2'h2 : 2'h3;
  endfunction : band

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pd = 9'h000;
    md = 3'h6;
    fails = 0;
    comparisons = 0;
    @(posedge clk);
    boot(9'h000, 3'h6);
    xfer(1'b0, PCC_SETTINGS_ADDR, 32'h0, 32'h0000010b, 1'b0);
    measure(58, 62);
    xfer(1'b1, PCC_SETTINGS_ADDR, 32'h0, 32'h0, 1'b1);
    pd <= 9'h1ff;
    repeat (8) @(posedge clk);
    xfer(1'b0, PCC_SETTINGS_ADDR, 32'h0, 32'h0000010b, 1'b0);
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, PCC_SPEED_ADDR, 32'(c) << 24, 32'h0, 1'b0);
      xfer(1'b0, PCC_SETTINGS_ADDR, 32'h0, {23'h0, band(c + 5), 2'h0, 5'(c + 4)}, 1'b0);
      xfer(1'b0, PCC_SPEED_ADDR, 32'h0, 32'(c) << 24, 1'b0);
    end
    measure(98, 102);
    xfer(1'b0, 32'hffb00010, 32'h0, 32'h0, 1'b1);
    boot(9'h108, 3'h7);
    xfer(1'b0, PCC_SETTINGS_ADDR, 32'h0, 32'h00000003, 1'b0);
    measure(19, 21);
    for (int i = 0; i < 8; i++) mode_chk(3'(i));
    conclude();
  end

  // Watchdog against a hung run
  initial begin
    #50us;
    fails++;
    conclude();
  end
endmodule : tb
`default_nettype wire

// file: hdl/pcc_pkg.sv
// Notes on behaviour
// - Oscillator mode passes crystal clock through unmultiplied.
// - Reference clock is input clock divided by five.
// - PLL mode bus clock is crystal/4 times multiplier+1.
// - Settings load from nine straps at bootup.
// - Straps A7..A4 and A2 stored inverted.
// - Undriven straps read one; pulldowns select zero.
// - Settings not writable; speed register changes multiplier.
// - Charge-pump field bits 8:7, default 10.
// - Output divider field bits 6:5, default 00.
// - Multiplier field bits 4:0, default 01011.
// - Unstrapped with 18.432 MHz crystal gives 55.3 MHz.
// - Decode three mode inputs; other codes invalid.
package pcc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] PCC_SPEED_ADDR = 32'hffb00008;
  localparam logic [31:0] PCC_SETTINGS_ADDR = 32'hffb00040;
  localparam logic [31:0] PCC_MODE_ADDR = 32'hffb00044;

  // ---------------------------------------------------------------
  // Settings fields and strap handling
  // ---------------------------------------------------------------
  localparam int PCC_STRAP_W = 9;
  localparam int PCC_CP_LSB = 7;
  localparam int PCC_DIV_LSB = 5;
  localparam int PCC_MUL_LSB = 0;
  localparam logic [8:0] PCC_STRAP_INV = 9'h0f4;
  localparam logic [8:0] PCC_SETTINGS_RST = 9'h10b;

  // ---------------------------------------------------------------
  // Speed control field
  // ---------------------------------------------------------------
  localparam int PCC_SPEED_LSB = 24;
  localparam logic [3:0] PCC_SPEED_RST = 4'h9;
  localparam logic [4:0] PCC_SPEED_MUL_OFS = 5'h04;

  // Multiplier+1 bounds of the charge-pump bands
  localparam logic [5:0] PCC_CP_BAND1 = 6'h04;
  localparam logic [5:0] PCC_CP_BAND2 = 6'h08;
  localparam logic [5:0] PCC_CP_BAND3 = 6'h10;

  // ---------------------------------------------------------------
  // Reference divider and mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] PCC_REF_EDGES = 3'h5;
  localparam logic [2:0] PCC_MODE_EXT_SCAN = 3'h3;
  localparam logic [2:0] PCC_MODE_PLL_SCAN = 3'h4;
  localparam logic [2:0] PCC_MODE_PLL_DBG = 3'h6;
  localparam logic [2:0] PCC_MODE_EXT_DBG = 3'h7;
  localparam int PCC_MODE_PLL_BIT = 0;
  localparam int PCC_MODE_DBG_BIT = 1;
  localparam int PCC_MODE_VALID_BIT = 2;
  localparam int PCC_MODE_CODE_LSB = 4;

endpackage : pcc_pkg

// file: hdl/pcc_strap.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_strap
  import pcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic in_reset_i,
  input wire logic [PCC_STRAP_W-1:0] pulldown_i,
  output logic [PCC_STRAP_W-1:0] latched_o
);

  typedef struct packed {
    logic [PCC_STRAP_W-1:0] meta;
    logic [PCC_STRAP_W-1:0] sync;
    logic [PCC_STRAP_W-1:0] cap;
  } pcc_strap_t;

  pcc_strap_t r;
  pcc_strap_t next_r;

  // Pull-ups, synchroniser and capture while reset holds
  always_comb begin
    next_r = r;
    next_r.meta = ~pulldown_i;
    next_r.sync = r.meta;
    if (in_reset_i) begin
      next_r.cap = r.sync ^ PCC_STRAP_INV;
    end
  end

  // No reset: these flops must sample while reset is held
  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  assign latched_o = r.cap;

endmodule : pcc_strap
`default_nettype wire

// file: hdl/pcc_synth.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_synth #(
  parameter int PERIOD_W = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic [PERIOD_W-1:0] period_i,
  input wire logic [5:0] mult_i,
  output logic synth_clk_o
);

  localparam int AW = PERIOD_W + 2;

  typedef struct packed {
    logic [AW-1:0] acc;
    logic clk_q;
  } pcc_synth_t;

  pcc_synth_t r;
  pcc_synth_t next_r;
  logic [AW-1:0] sum;
  logic [AW-1:0] lim;

  // Phase accumulator: m/2 toggles per crystal period
  always_comb begin
    next_r = r;
    sum = r.acc + AW'(mult_i);
    lim = {1'b0, period_i, 1'b0};
    if (!enable_i) begin
      next_r.acc = '0;
      next_r.clk_q = 1'b0;
    end else if (sum >= lim) begin
      next_r.acc = sum - lim;
      next_r.clk_q = ~r.clk_q;
    end else begin
      next_r.acc = sum;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign synth_clk_o = r.clk_q;

endmodule : pcc_synth
`default_nettype wire

// file: hdl/pcc_top.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
#(
  parameter int PERIOD_W = 8
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,

  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,

  input wire logic [PCC_STRAP_W-1:0] STRAP_PULLDOWN_I,
  input wire logic PLL_TEST_SELECT_I,
  input wire logic SELFTEST_SELECT_I,
  input wire logic SCAN_SELECT_I,
  input wire logic CRYSTAL_IN_I,

  output logic BUS_CLK_O,
  output logic SLOW_REF_CLOCK_O,
  output logic PLL_MODE_O,
  output logic DEBUG_MODE_O,
  output logic MODE_VALID_O,
  output logic [1:0] CHARGE_PUMP_SEL_O,
  output logic [1:0] OUTPUT_DIVIDER_SEL_O,
  output logic [4:0] FEEDBACK_MULTIPLIER_O
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic rst_sync_d;
    logic [2:0] mode_meta;
    logic [2:0] mode_sync;
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_d;
    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] period;
    logic [2:0] ref_cnt;
    logic ref_clk;
    logic bus_clk;
    logic [PCC_STRAP_W-1:0] settings;
    logic [3:0] speed;
    logic [31:0] prdata;
  } pcc_state_t;

  pcc_state_t r;
  pcc_state_t next_r;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Charge-pump band for a multiplier+1 value
  function automatic logic [1:0] cp_band(input logic [5:0] m);
    logic [1:0] c;
    if (m < PCC_CP_BAND1) begin
      c = 2'h0;
    end else if (m < PCC_CP_BAND2) begin
      c = 2'h1;
    end else if (m < PCC_CP_BAND3) begin
      c = 2'h2;
    end else begin
      c = 2'h3;
    end
    return c;
  endfunction : cp_band

  // Mode code to {valid, debug, pll}
  function automatic logic [2:0] mode_dec(input logic [2:0] code);
    logic [2:0] d;
    case (code)
      PCC_MODE_EXT_SCAN: d = 3'h4;
      PCC_MODE_PLL_SCAN: d = 3'h5;
      PCC_MODE_PLL_DBG: d = 3'h7;
      PCC_MODE_EXT_DBG: d = 3'h6;
      default: d = 3'h0;
    endcase
    return d;
  endfunction : mode_dec

  // ---------------------------------------------------------------
  // Combinational nets
  // ---------------------------------------------------------------

  logic in_reset;
  logic release_pulse;
  logic [2:0] mode;
  logic pll_mode;
  logic xtal_rise;
  logic xtal_edge;
  logic [5:0] mult;
  logic [3:0] new_speed;
  logic [4:0] new_mul;
  logic synth_clk;
  logic [PCC_STRAP_W-1:0] strap_val;
  logic hit_set;
  logic hit_spd;
  logic hit_mode;
  logic hit_any;
  logic access;
  logic wr_speed;
  logic [31:0] rd_mux;

  // Reset status seen by the clocked logic
  assign in_reset = ~r.rst_sync;
  assign release_pulse = r.rst_sync & ~r.rst_sync_d;

  // Mode decode of synchronised select inputs
  assign mode = mode_dec(r.mode_sync);
  assign pll_mode = mode[0] & mode[2];

  // Crystal edges after synchronisation
  assign xtal_rise = r.xtal_sync & ~r.xtal_d;
  assign xtal_edge = r.xtal_sync ^ r.xtal_d;

  // Multiplier plus one feeds the synthesiser
  assign mult = {1'b0, r.settings[PCC_MUL_LSB +: 5]} + 6'h01;

  // Speed write maps a code to a new multiplier
  assign new_speed = PWDATA_I[PCC_SPEED_LSB +: 4];
  assign new_mul = {1'b0, new_speed} + PCC_SPEED_MUL_OFS;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------

  assign hit_set = (PADDR_I == PCC_SETTINGS_ADDR);
  assign hit_spd = (PADDR_I == PCC_SPEED_ADDR);
  assign hit_mode = (PADDR_I == PCC_MODE_ADDR);
  assign hit_any = hit_set | hit_spd | hit_mode;
  assign access = PSEL_I & PENABLE_I;

  // Only the speed register accepts writes
  assign wr_speed = access & PWRITE_I & hit_spd & PSTRB_I[3];

  // Read data selection
  always_comb begin
    rd_mux = 32'h0;
    if (hit_set) begin
      rd_mux[PCC_STRAP_W-1:0] = r.settings;
    end else if (hit_spd) begin
      rd_mux[PCC_SPEED_LSB +: 4] = r.speed;
    end else if (hit_mode) begin
      rd_mux[PCC_MODE_PLL_BIT] = mode[0];
      rd_mux[PCC_MODE_DBG_BIT] = mode[1];
      rd_mux[PCC_MODE_VALID_BIT] = mode[2];
      rd_mux[PCC_MODE_CODE_LSB +: 3] = r.mode_sync;
    end
  end

  // Zero wait states; error on unmapped or read-only write
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & (~hit_any | (PWRITE_I & ~hit_spd));

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------

  // Strap capture during reset
  pcc_strap u_strap (
    .clk_i(CLK_I),
    .in_reset_i(in_reset),
    .pulldown_i(STRAP_PULLDOWN_I),
    .latched_o(strap_val)
  );

  // Bus clock synthesiser for PLL mode
  pcc_synth #(
    .PERIOD_W(PERIOD_W)
  ) u_synth (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .enable_i(pll_mode & (r.period != '0)),
    .period_i(r.period),
    .mult_i(mult),
    .synth_clk_o(synth_clk)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  always_comb begin
    next_r = r;

    // Reset release synchroniser
    next_r.rst_meta = 1'b1;
    next_r.rst_sync = r.rst_meta;
    next_r.rst_sync_d = r.rst_sync;

    // Mode pin synchroniser
    next_r.mode_meta = {PLL_TEST_SELECT_I, SELFTEST_SELECT_I, SCAN_SELECT_I};
    next_r.mode_sync = r.mode_meta;

    // Crystal synchroniser and edge history
    next_r.xtal_meta = CRYSTAL_IN_I;
    next_r.xtal_sync = r.xtal_meta;
    next_r.xtal_d = r.xtal_sync;

    // Crystal period measured in system cycles
    if (xtal_rise) begin
      next_r.cnt = '0;
      next_r.period = r.cnt + PERIOD_W'(1);
    end else if (r.cnt != '1) begin
      next_r.cnt = r.cnt + PERIOD_W'(1);
    end

    // Reference clock toggles every five crystal edges
    if (xtal_edge) begin
      if (r.ref_cnt == PCC_REF_EDGES - 3'h1) begin
        next_r.ref_cnt = 3'h0;
        next_r.ref_clk = ~r.ref_clk;
      end else begin
        next_r.ref_cnt = r.ref_cnt + 3'h1;
      end
    end

    // Bus clock source select
    if (pll_mode) begin
      next_r.bus_clk = synth_clk;
    end else begin
      next_r.bus_clk = r.xtal_sync;
    end

    // Settings load at release, multiplier update later
    if (release_pulse) begin
      next_r.settings = strap_val;
    end else if (wr_speed) begin
      next_r.speed = new_speed;
      next_r.settings[PCC_MUL_LSB +: 5] = new_mul;
      next_r.settings[PCC_CP_LSB +: 2] = cp_band({1'b0, new_mul} + 6'h01);
    end

    // Read data captured in the setup cycle
    if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      next_r.prdata = rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r <= '0;
      r.settings <= PCC_SETTINGS_RST;
      r.speed <= PCC_SPEED_RST;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign PRDATA_O = r.prdata;
  assign BUS_CLK_O = r.bus_clk;
  assign SLOW_REF_CLOCK_O = r.ref_clk;
  assign PLL_MODE_O = pll_mode;
  assign DEBUG_MODE_O = mode[1];
  assign MODE_VALID_O = mode[2];

  // Settings fields
  assign CHARGE_PUMP_SEL_O = r.settings[PCC_CP_LSB +: 2];
  assign OUTPUT_DIVIDER_SEL_O = r.settings[PCC_DIV_LSB +: 2];
  assign FEEDBACK_MULTIPLIER_O = r.settings[PCC_MUL_LSB +: 5];

endmodule : pcc_top
`default_nettype wire
